// File: src/mrx_rx_frame_cfg.v
// rx frame configuration registers: unicast enables, max length,
// buffer offset, low priority filter threshold, event interrupts
// assumes a classic wishbone master and same-clock frame reports
//
// Summary of operation
// - writing one clears that channel's unicast enable
// - writing zero to clear leaves enable unchanged
// - sixteen-bit max frame length, resets to 1518
// - byte count above max marks long frame
// - long frame without errors is oversized
// - long frame with crc/code/align error is jabber
// - buffer offset copied into start-of-packet descriptor
// - data starts after offset skipped bytes
// - one buffer offset shared by all channels
// - eight-bit free buffer filter threshold held
// - threshold compared with each channel free count
// - set register writes one to enable channel
`include "mrx_regs.vh"
module mrx_rx_frame_cfg (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // frame end report from the receive path
  input wire frmDone,
  input wire [15:0] frmByteCount,
  input wire frmCrcErr,
  input wire frmCodeErr,
  input wire frmAlignErr,
  input wire frmLowPriority,
  input wire [2:0] frmChannel,
  // per-channel free buffer counts, channel n in bits 16n+15:16n
  input wire [127:0] chanFreeBufferCount,
  // descriptor start-of-packet write
  input wire sopDescReq,
  output reg [15:0] sopBufferOffset_r,
  output reg sopDescValid_r,
  // configuration outputs
  output wire [7:0] unicastEnable,
  output wire [15:0] rxMaxFrameLength,
  output wire [15:0] rxBufferStartOffset,
  output reg [7:0] lowPriorityDrop_r,
  // frame classification
  output wire longFrame,
  output wire oversizeFrame,
  output wire jabberFrame,
  output reg frameDropped_r,
  // interrupt
  output wire irq
);
  // register storage
  reg [7:0] ucEn_r;
  reg [15:0] maxLen_r;
  reg [15:0] bufOfs_r;
  reg [7:0] loThr_r;
  reg [`MRX_IRQ_W-1:0] irqStat_r;
  reg [`MRX_IRQ_W-1:0] irqMask_r;

  // event collection and read path
  reg [`MRX_IRQ_W-1:0] evt;
  reg [31:0] rdData;
  reg adrHit;

  // bus slave state, one-hot
  reg [1:0] busState_r;
  reg [1:0] busState_nxt;

  // request qualifiers
  wire req;
  wire wrEn;
  wire rdEn;
  wire wrLane0;
  wire wrLane1;

  // address decode
  wire hitUcSet;
  wire hitUcClr;
  wire hitMaxLen;
  wire hitBufOfs;
  wire hitLoThr;
  wire hitIrqStat;
  wire hitIrqMask;
  wire hitFrmStat;

  // classification, threshold compare, pending interrupts
  wire classValid;
  wire [7:0] belowThr;
  wire [`MRX_IRQ_W-1:0] irqPend;
  genvar g;

  localparam [1:0] BUS_IDLE = 2'b01;
  localparam [1:0] BUS_ACK = 2'b10;
  localparam [7:0] UC_RST = `MRX_UC_RST;

  // one wait state: a request is taken in idle and answered from the
  // ack state, which always returns to idle so that ack is a pulse
  always @* begin
    busState_nxt = busState_r;
    case (busState_r)
      BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          busState_nxt = BUS_ACK;
        end
      end
      BUS_ACK: begin
        busState_nxt = BUS_IDLE;
      end
      default: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busState_r <= BUS_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  // a write lands at the edge where the master sees ack, so address and
  // data are taken while the master is still bound to hold them
  assign req = wb_cyc_i & wb_stb_i & (busState_r == BUS_IDLE);
  assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & (busState_r == BUS_ACK);
  assign rdEn = req & ~wb_we_i;
  assign wrLane0 = wrEn & wb_sel_i[0];
  assign wrLane1 = wrEn & wb_sel_i[1];
  // unmapped reads return zero with a normal ack; err never raised
  assign wb_err_o = 1'b0;

  assign hitUcSet = (wb_adr_i == `MRX_ADR_UC_SET);
  assign hitUcClr = (wb_adr_i == `MRX_ADR_UC_CLR);
  assign hitMaxLen = (wb_adr_i == `MRX_ADR_MAXLEN);
  assign hitBufOfs = (wb_adr_i == `MRX_ADR_BUFOFS);
  assign hitLoThr = (wb_adr_i == `MRX_ADR_LOTHR);
  assign hitIrqStat = (wb_adr_i == `MRX_ADR_IRQ_STAT);
  assign hitIrqMask = (wb_adr_i == `MRX_ADR_IRQ_MASK);
  assign hitFrmStat = (wb_adr_i == `MRX_ADR_FRM_STAT);

  // per-channel unicast enables: a one on the set address raises the
  // enable, a one on the clear address drops it, a zero does nothing;
  // set and clear are distinct addresses so they never meet
  generate
    for (g = 0; g < `MRX_NCHAN; g = g + 1) begin : gUc
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          ucEn_r[g] <= UC_RST[g];
        end else if (wrLane0 && hitUcSet && wb_dat_i[g]) begin
          ucEn_r[g] <= 1'b1;
        end else if (wrLane0 && hitUcClr && wb_dat_i[g]) begin
          ucEn_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign unicastEnable = ucEn_r;

  // maximum frame length; reserved upper half is not stored
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      maxLen_r <= `MRX_MAXLEN_RST;
    end else if (hitMaxLen) begin
      if (wrLane0) begin
        maxLen_r[7:0] <= wb_dat_i[7:0];
      end
      if (wrLane1) begin
        maxLen_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  assign rxMaxFrameLength = maxLen_r;

  // one buffer offset for every channel, so no per-channel copy
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bufOfs_r <= `MRX_BUFOFS_RST;
    end else if (hitBufOfs) begin
      if (wrLane0) begin
        bufOfs_r[7:0] <= wb_dat_i[7:0];
      end
      if (wrLane1) begin
        bufOfs_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  assign rxBufferStartOffset = bufOfs_r;

  // low priority filter threshold, one byte
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loThr_r <= `MRX_LOTHR_RST;
    end else if (hitLoThr && wrLane0) begin
      loThr_r <= wb_dat_i[7:0];
    end
  end

  // interrupt mask, same layout as the status bits
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask_r <= {`MRX_IRQ_W{1'b0}};
    end else if (hitIrqMask && wrLane0) begin
      irqMask_r <= wb_dat_i[`MRX_IRQ_W-1:0];
    end
  end

  mrx_frame_class uClass (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .frmDone(frmDone),
    .frmByteCount(frmByteCount),
    .frmCrcErr(frmCrcErr),
    .frmCodeErr(frmCodeErr),
    .frmAlignErr(frmAlignErr),
    .maxLen(maxLen_r),
    .classValid_r(classValid),
    .longFrame_r(longFrame),
    .oversizeFrame_r(oversizeFrame),
    .jabberFrame_r(jabberFrame)
  );

  // a threshold of zero never filters, since no count is below zero;
  // each channel's compare result is also kept for software to read
  generate
    for (g = 0; g < `MRX_NCHAN; g = g + 1) begin : gThr
      assign belowThr[g] =
        chanFreeBufferCount[16*g+15:16*g] < {8'h00, loThr_r};
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          lowPriorityDrop_r[g] <= 1'b0;
        end else begin
          lowPriorityDrop_r[g] <= belowThr[g];
        end
      end
    end
  endgenerate

  // the drop decision uses the live compare of the frame's own channel
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frameDropped_r <= 1'b0;
    end else begin
      frameDropped_r <= frmDone & frmLowPriority & belowThr[frmChannel];
    end
  end

  // offset goes out unchanged; the dma skips that many bytes so that
  // zero puts data at byte one and fifteen at byte sixteen
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sopBufferOffset_r <= 16'h0000;
      sopDescValid_r <= 1'b0;
    end else begin
      sopDescValid_r <= sopDescReq;
      if (sopDescReq) begin
        sopBufferOffset_r <= bufOfs_r;
      end
    end
  end

  // classification pulses count only with the classifier's valid
  always @* begin
    evt = {`MRX_IRQ_W{1'b0}};
    if (classValid) begin
      evt[`MRX_IRQ_LONG] = longFrame;
      evt[`MRX_IRQ_OVER] = oversizeFrame;
      evt[`MRX_IRQ_JAB] = jabberFrame;
    end
    evt[`MRX_IRQ_DROP] = frameDropped_r;
  end

  // sticky events; a new event wins over a write-one-to-clear so that
  // an event landing during the clear is never lost
  generate
    for (g = 0; g < `MRX_IRQ_W; g = g + 1) begin : gIrq
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          irqStat_r[g] <= 1'b0;
        end else if (evt[g]) begin
          irqStat_r[g] <= 1'b1;
        end else if (wrLane0 && hitIrqStat && wb_dat_i[g]) begin
          irqStat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  assign irqPend = irqStat_r & irqMask_r;
  assign irq = |irqPend;

  // read mux; reserved upper bits are zero
  always @* begin
    rdData = 32'h00000000;
    adrHit = 1'b1;
    if (hitUcSet || hitUcClr) begin
      rdData[7:0] = ucEn_r;
    end else if (hitMaxLen) begin
      rdData[15:0] = maxLen_r;
    end else if (hitBufOfs) begin
      rdData[15:0] = bufOfs_r;
    end else if (hitLoThr) begin
      rdData[7:0] = loThr_r;
    end else if (hitIrqStat) begin
      rdData[`MRX_IRQ_W-1:0] = irqStat_r;
    end else if (hitIrqMask) begin
      rdData[`MRX_IRQ_W-1:0] = irqMask_r;
    end else if (hitFrmStat) begin
      rdData[7:0] = lowPriorityDrop_r;
    end else begin
      adrHit = 1'b0;
    end
  end

  // ack follows the request by one cycle; read data is captured with it
  // and then holds until the next read
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rdEn) begin
        wb_dat_o <= adrHit ? rdData : 32'h00000000;
      end
    end
  end
endmodule // mrx_rx_frame_cfg

// File: src/mrx_regs.vh
// register offsets, field positions, reset values for the rx config block
// assumes a 32-bit classic wishbone slave, byte addresses, word aligned
`ifndef MRX_REGS_VH
`define MRX_REGS_VH
`define MRX_ADR_UC_SET 8'h00
`define MRX_ADR_UC_CLR 8'h04
`define MRX_ADR_MAXLEN 8'h08
`define MRX_ADR_BUFOFS 8'h0C
`define MRX_ADR_LOTHR 8'h10
`define MRX_ADR_IRQ_STAT 8'h14
`define MRX_ADR_IRQ_MASK 8'h18
`define MRX_ADR_FRM_STAT 8'h1C
`define MRX_MAXLEN_RST 16'h05EE
`define MRX_BUFOFS_RST 16'h0000
`define MRX_LOTHR_RST 8'h00
`define MRX_UC_RST 8'h00
`define MRX_NCHAN 8
`define MRX_IRQ_LONG 0
`define MRX_IRQ_OVER 1
`define MRX_IRQ_JAB 2
`define MRX_IRQ_DROP 3
`define MRX_IRQ_W 4
`endif

// File: src/mrx_frame_class.v
// classifies one received frame against the maximum length
// assumes frame status inputs are synchronous to core_clk
`include "mrx_regs.vh"
module mrx_frame_class (
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // frame end report
  input wire frmDone,
  input wire [15:0] frmByteCount,
  input wire frmCrcErr,
  input wire frmCodeErr,
  input wire frmAlignErr,
  input wire [15:0] maxLen,
  // result
  output reg classValid_r,
  output reg longFrame_r,
  output reg oversizeFrame_r,
  output reg jabberFrame_r
);
  wire isLong;
  wire anyErr;
  assign isLong = frmByteCount > maxLen;
  assign anyErr = frmCrcErr | frmCodeErr | frmAlignErr;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      classValid_r <= 1'b0;
      longFrame_r <= 1'b0;
      oversizeFrame_r <= 1'b0;
      jabberFrame_r <= 1'b0;
    end else begin
      classValid_r <= frmDone;
      longFrame_r <= frmDone & isLong;
      oversizeFrame_r <= frmDone & isLong & ~anyErr;
      jabberFrame_r <= frmDone & isLong & anyErr;
    end
  end
endmodule // mrx_frame_class

// File: testbench/mrx_phy_model.sv
// frame partner: one end-of-frame report per go pulse
// assumes go is a one-cycle pulse from the bench
module mrx_phy_model (
  // bench command
  input wire core_clk,
  input wire go,
  input wire [15:0] len,
  input wire [2:0] err,
  // end-of-frame report
  output logic frmDone = 1'b0,
  output logic [2:0] frmErr = 3'h0,
  output logic [15:0] frmByteCount = 16'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // between reports fields flip so stale values are never trusted
  always @(posedge core_clk) begin
    frmDone <= go;
    frmByteCount <= go ? len : ~frmByteCount;
    frmErr <= go ? err : ~err;
  end
endmodule // mrx_phy_model

// File: testbench/mrx_rx_frame_cfg_chk.sv
// port checks for the rx frame config block
// assumes one clock; bound to each instance
module mrx_rx_frame_cfg_chk (
  // watched ports
  input wire core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_ack_o, frmDone,
  input wire frmCrcErr, frmCodeErr, frmAlignErr, sopDescReq,
  input wire longFrame, oversizeFrame, jabberFrame, sopDescValid_r,
  input wire [15:0] frmByteCount, rxMaxFrameLength,
  input wire [15:0] sopBufferOffset_r, rxBufferStartOffset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire isLong = frmByteCount > rxMaxFrameLength;
  wire hasErr = frmCrcErr | frmCodeErr | frmAlignErr;
  wire isOver = isLong & !hasErr;
  wire isJab = isLong & hasErr;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack");
  a_max_reset: assert property ($rose(rst_b) |->
    rxMaxFrameLength == 16'h05EE) else $error("max reset");
  a_long_class: assert property (frmDone |=>
    longFrame == $past(isLong)) else $error("long");
  a_over_class: assert property (frmDone |=>
    oversizeFrame == $past(isOver)) else $error("oversize");
  a_jab_class: assert property (frmDone |=>
    jabberFrame == $past(isJab)) else $error("jabber");
  a_class_quiet: assert property (!frmDone |=>
    !(longFrame | oversizeFrame | jabberFrame)) else $error("stray");
  a_sop_offset: assert property (sopDescReq |=> sopDescValid_r &&
    sopBufferOffset_r == $past(rxBufferStartOffset)) else $error("sop");
endmodule // mrx_rx_frame_cfg_chk
bind mrx_rx_frame_cfg mrx_rx_frame_cfg_chk mrx_rx_frame_cfg_chk_i (.*);

// File: testbench/mrx_rx_frame_cfg_tb.sv
// self-checking bench for the rx frame config block
// assumes one-cycle wishbone answer and the frame partner model
`include "mrx_regs.vh"
module mrx_rx_frame_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_b = 0, cyc = 0, we = 0, go = 0, sop = 0, lp = 0;
  wire [7:0] ue;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rs = 32'h24, e, msk = 32'h0, q[$];
  logic [15:0] len = 16'h0;
  logic [2:0] err = 3'h0;
  logic [127:0] cfb = 128'h0;
  wire [31:0] rdat;
  wire [15:0] cnt, ofs;
  wire [2:0] fe;
  wire ack, dne, irq;
  int mismatches = 0, n_checks = 0;
  always #2 core_clk = ~core_clk;
  mrx_phy_model mrx_phy_model_i (.core_clk, .go, .len, .err,
    .frmDone(dne), .frmErr(fe), .frmByteCount(cnt));
  mrx_rx_frame_cfg mrx_rx_frame_cfg_i (.core_clk, .rst_b, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(),
    .frmDone(dne), .frmByteCount(cnt), .frmCrcErr(fe[0]),
    .frmCodeErr(fe[1]), .frmAlignErr(fe[2]), .frmLowPriority(lp),
    .frmChannel(3'h5), .chanFreeBufferCount(cfb), .sopDescReq(sop),
    .sopBufferOffset_r(ofs), .sopDescValid_r(), .unicastEnable(ue),
    .rxMaxFrameLength(), .rxBufferStartOffset(), .lowPriorityDrop_r(),
    .longFrame(), .oversizeFrame(), .jabberFrame(), .frameDropped_r(),
    .irq(irq));
  function automatic [31:0] xs(input [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task chk(input [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, s, x);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    int i;
    @(posedge core_clk);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      complete_run;
    end
    cyc <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] x);
    q.push_back(x);
    wb(0, a, 32'h0);
  endtask
  // read results are matched against the oldest note
  always @(posedge core_clk) if (ack === 1'b1 && !we) chk(rdat, q.pop_front());
  task frm(input [15:0] l, input [2:0] r, input [31:0] x);
    @(posedge core_clk);
    go <= 1;
    len <= l;
    err <= r;
    @(posedge core_clk);
    go <= 0;
    repeat (3) @(posedge core_clk);
    rd(`MRX_ADR_IRQ_STAT, x);
    chk(irq, 32'((x & msk) != 0));
    wb(1, `MRX_ADR_IRQ_STAT, 32'hF);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1;
    rd(`MRX_ADR_MAXLEN, 32'h5EE);
    rd(`MRX_ADR_LOTHR, 32'h0);
    $display("reset test done");
    wb(1, `MRX_ADR_UC_SET, 32'hFF);
    wb(1, `MRX_ADR_UC_CLR, 32'hA5);
    wb(1, `MRX_ADR_UC_CLR, 32'h0);
    rd(`MRX_ADR_UC_CLR, 32'h5A);
    wb(1, `MRX_ADR_UC_SET, 32'hFFFF_FF01);
    rd(`MRX_ADR_UC_SET, 32'h5B);
    chk(ue, 32'h5B);
    $display("unicast test done");
    wb(1, `MRX_ADR_MAXLEN, 32'hFFFF_FFFF);
    rd(`MRX_ADR_MAXLEN, 32'hFFFF);
    wb(1, `MRX_ADR_LOTHR, 32'hFFFF_FFFF);
    rd(`MRX_ADR_LOTHR, 32'hFF);
    rd(8'h40, 32'h0);
    $display("field test done");
    msk = 32'hF;
    wb(1, `MRX_ADR_IRQ_MASK, msk);
    wb(1, `MRX_ADR_MAXLEN, 32'h64);
    frm(16'h64, 3'h7, 32'h0);
    frm(16'h65, 3'h0, 32'h3);
    for (int k = 0; k < 3; k++) frm(16'hFFFF, 3'h1 << k, 32'h5);
    lp <= 1'b1;
    frm(16'h10, 3'h0, 32'h8);
    lp <= 1'b0;
    msk = 32'h0;
    wb(1, `MRX_ADR_IRQ_MASK, msk);
    frm(16'h65, 3'h0, 32'h3);
    $display("frame test done");
    wb(1, `MRX_ADR_BUFOFS, 32'hFFFF_FFFF);
    rd(`MRX_ADR_BUFOFS, 32'hFFFF);
    wb(1, `MRX_ADR_BUFOFS, 32'hF);
    @(posedge core_clk) sop <= 1;
    @(posedge core_clk) sop <= 0;
    @(negedge core_clk) chk(ofs, 32'hF);
    $display("sop test done");
    rd(`MRX_ADR_FRM_STAT, 32'hFF);
    wb(1, `MRX_ADR_LOTHR, 32'h80);
    for (int j = 0; j < 4; j++) begin
      e = 32'h0;
      @(posedge core_clk);
      for (int k = 0; k < 8; k++) begin
        rs = xs(rs);
        cfb[16*k +: 16] <= {7'h0, rs[8:0]};
        e[k] = rs[8:0] < 9'h080;
      end
      rd(`MRX_ADR_FRM_STAT, e);
    end
    wb(1, `MRX_ADR_LOTHR, 32'h0);
    rd(`MRX_ADR_FRM_STAT, 32'h0);
    $display("threshold test done");
    complete_run;
  end
endmodule // mrx_rx_frame_cfg_tb
